/* File: design/gtu_pkg.sv */
// package: register map, field positions, reset values and timing constants
package gtu_pkg;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_CFG      = 8'h00; // block_configuration
    localparam logic [7:0] ADDR_AMODE    = 8'h04; // first_half_mode_reg
    localparam logic [7:0] ADDR_BMODE    = 8'h08; // second_half_mode_reg
    localparam logic [7:0] ADDR_CTL      = 8'h0C; // timer_control_reg
    localparam logic [7:0] ADDR_IMASK    = 8'h18; // interrupt_mask_reg
    localparam logic [7:0] ADDR_RAW      = 8'h1C; // raw_interrupt_status
    localparam logic [7:0] ADDR_MSK      = 8'h20; // masked_interrupt_status
    localparam logic [7:0] ADDR_ICLR     = 8'h24; // interrupt_clear_reg
    localparam logic [7:0] ADDR_AILR     = 8'h28; // first_half_interval_load
    localparam logic [7:0] ADDR_BILR     = 8'h2C; // second_half_interval_load
    localparam logic [7:0] ADDR_AMATCH   = 8'h30; // first_half_match
    localparam logic [7:0] ADDR_BMATCH   = 8'h34;
    localparam logic [7:0] ADDR_APRE     = 8'h38; // first_half_prescale
    localparam logic [7:0] ADDR_BPRE     = 8'h3C; // second_half_prescale
    localparam logic [7:0] ADDR_ACNT     = 8'h48; // first_half_count
    localparam logic [7:0] ADDR_BCNT     = 8'h4C; // second_half_count

    // configuration codes
    localparam logic [2:0] CFG_32_TIMER  = 3'h0;
    localparam logic [2:0] CFG_32_CLOCK  = 3'h1;
    localparam logic [2:0] CFG_16_SPLIT  = 3'h4;

    // mode field codes
    localparam logic [1:0] MODE_ONESHOT  = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;

    // timer_control_reg field positions
    localparam int CTL_A_EN      = 0;  // first_half_enable
    localparam int CTL_A_STALL   = 1;  // first_half_stall_ctrl
    localparam int CTL_CLK_EN    = 4;  // clock_mode_enable
    localparam int CTL_A_OTE     = 5;  // output_trigger_enable
    localparam int CTL_B_EN      = 8;
    localparam int CTL_B_STALL   = 9;
    localparam int CTL_B_OTE     = 13;

    // interrupt flag positions
    localparam int IRQ_A_TIMEOUT = 0;  // timeout flag, first half
    localparam int IRQ_CLK_MATCH = 3;  // clock match flag
    localparam int IRQ_B_TIMEOUT = 8;  // timeout flag, second half

    // reset values
    localparam logic [15:0] RST_COUNT    = 16'hFFFF;
    localparam logic [15:0] RST_LOAD     = 16'hFFFF;
    localparam logic [7:0]  RST_PRESCALE = 8'h00;
    localparam logic [31:0] CLK_FIRST    = 32'h00000001;
    localparam logic [31:0] CLK_ROLL     = 32'h00000000;

    // clock-mode divider: 32768 input edges make one second
    localparam int          CLK_DIV_BITS = 15;

    // one bus request as seen by the slave
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  sel;
    } gtu_req_s;

    // bits of the two timer halves kept together
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] load;
    } gtu_half_s;

endpackage

/* File: design/gtu_top.sv */
// general timer unit: two 16-bit halves, 32-bit timer and clock modes
`timescale 1ns/1ps
module gtu_top
    import gtu_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    // wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // capture_compare_pin inputs, even and odd
    input  wire logic        CCP_EVEN_I,
    input  wire logic        CCP_ODD_I,
    // outputs
    output logic             ADC_TRIG_O,
    output logic             IRQ_O
);

    // register file
    logic [2:0]  cfg_r;
    logic [1:0]  amode_r;
    logic [1:0]  bmode_r;
    logic [15:0] ctl_r;
    logic [15:0] imask_r;
    logic [15:0] raw_r;
    gtu_half_s   ha_r;
    gtu_half_s   hb_r;
    logic [15:0] cnt_a_r;
    logic [15:0] cnt_b_r;
    logic [15:0] load_a_r;
    logic [15:0] load_b_r;
    logic [15:0] amatch_r;
    logic [15:0] bmatch_r;
    logic [7:0]  apre_r;
    logic [7:0]  bpre_r;
    logic        clk_seen_r;
    logic        trig_r;
    logic        ack_r;
    logic [31:0] dat_r;

    // pin synchronisers, edge history and clock divider
    logic [1:0]  even_sync_r;
    logic [1:0]  odd_sync_r;
    logic        even_prev_r;
    logic [CLK_DIV_BITS-1:0] div_r;

    gtu_req_s    req;
    logic        bus_go;
    logic        wr_go;
    logic        is32;
    logic        clk_mode;
    logic        tick_1hz;
    logic [31:0] cnt32;
    logic [31:0] load32;
    logic        run32;
    logic        zero32;
    logic        zero_a;
    logic        zero_b;
    logic        run_a;
    logic        run_b;
    logic        clk_match;
    logic [15:0] clr_bits;
    logic [15:0] set_bits;
    logic [3:0]  wr_lane;

    // write decode used for every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // bus request bundle; ack pulse lasts one cycle so each request is once
    always_comb
    begin
        req.wr   = WE_I;
        req.addr = ADR_I;
        req.data = DAT_I;
        req.sel  = SEL_I;
    end
    assign bus_go   = CYC_I && STB_I && !ack_r;
    assign wr_go    = bus_go && req.wr;
    assign wr_lane  = req.sel;

    // halves bundled from separate flops, so counts and loads each have
    // exactly one writing process
    assign ha_r = '{cnt: cnt_a_r, load: load_a_r};
    assign hb_r = '{cnt: cnt_b_r, load: load_b_r};

    // mode decode
    assign is32     = (cfg_r == CFG_32_TIMER) || (cfg_r == CFG_32_CLOCK);
    assign clk_mode = (cfg_r == CFG_32_CLOCK);
    assign cnt32    = {hb_r.cnt, ha_r.cnt};
    assign load32   = {hb_r.load, ha_r.load};
    assign zero32   = (cnt32 == 32'h0);
    assign zero_a   = (ha_r.cnt == 16'h0);
    assign zero_b   = (hb_r.cnt == 16'h0);
    assign clk_match = clk_mode && ctl_r[CTL_A_EN] && tick_1hz
                       && (cnt32 == {bmatch_r, amatch_r});

    // stall ignored when clock enable is set, 32-bit timer only; split halves stop whenever their own stall bit is set
    assign run32 = (cfg_r == CFG_32_TIMER) && ctl_r[CTL_A_EN]
                   && (!ctl_r[CTL_A_STALL] || ctl_r[CTL_CLK_EN]);
    assign run_a = (cfg_r == CFG_16_SPLIT) && ctl_r[CTL_A_EN]
                   && !ctl_r[CTL_A_STALL];
    assign run_b = (cfg_r == CFG_16_SPLIT) && ctl_r[CTL_B_EN]
                   && !ctl_r[CTL_B_STALL];

    // two-flop synchronisers for the capture pins
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            even_sync_r <= 2'h0;
            odd_sync_r  <= 2'h0;
            even_prev_r <= 1'b0;
        end
        else
        begin
            even_sync_r <= {even_sync_r[0], CCP_EVEN_I};
            odd_sync_r  <= {odd_sync_r[0], CCP_ODD_I};
            even_prev_r <= even_sync_r[1];
        end
    end

    // divider: one second per 32768 rising edges on the even pin only
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            div_r <= '0;
        else if (!(clk_mode && ctl_r[CTL_A_EN]))
            div_r <= '0;
        else if (even_sync_r[1] && !even_prev_r)
            div_r <= div_r + 1'b1;
    end
    assign tick_1hz = even_sync_r[1] && !even_prev_r && (&div_r);

    // event sets: set wins over a clear in the same cycle
    always_comb
    begin
        set_bits = 16'h0;
        set_bits[IRQ_A_TIMEOUT] = (run32 && zero32)
                                  || (run_a && zero_a);
        set_bits[IRQ_B_TIMEOUT] = run_b && zero_b;
        set_bits[IRQ_CLK_MATCH] = clk_match;
        clr_bits = (wr_go && hit(req.addr, ADDR_ICLR))
                   ? req.data[15:0] : 16'h0;
    end

    // raw flags are sticky until cleared
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            raw_r <= 16'h0;
        else
            raw_r <= (raw_r & ~clr_bits) | set_bits;
    end

    // control registers written by software
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            cfg_r    <= 3'h0;
            amode_r  <= 2'h0;
            bmode_r  <= 2'h0;
            imask_r  <= 16'h0;
            amatch_r <= 16'hFFFF;
            bmatch_r <= 16'hFFFF;
            apre_r   <= RST_PRESCALE;
            bpre_r   <= RST_PRESCALE;
        end
        else if (wr_go && wr_lane[0])
        begin
            if (hit(req.addr, ADDR_CFG))
                cfg_r <= req.data[2:0];
            if (hit(req.addr, ADDR_AMODE))
                amode_r <= req.data[1:0];
            if (hit(req.addr, ADDR_BMODE))
                bmode_r <= req.data[1:0];
            if (hit(req.addr, ADDR_IMASK))
                imask_r <= req.data[15:0];
            if (hit(req.addr, ADDR_AMATCH))
            begin
                amatch_r <= req.data[15:0];
                if (is32)
                    bmatch_r <= req.data[31:16];
            end
            if (hit(req.addr, ADDR_BMATCH))
                bmatch_r <= req.data[15:0];
            if (hit(req.addr, ADDR_APRE))
                apre_r <= req.data[7:0];
            if (hit(req.addr, ADDR_BPRE))
                bpre_r <= req.data[7:0];
        end
    end

    // control word; hardware clears enable on one-shot expiry
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            ctl_r <= 16'h0;
        else if (wr_go && wr_lane[0] && hit(req.addr, ADDR_CTL))
            ctl_r <= req.data[15:0];
        else
        begin
            // first half mode field alone steers the 32-bit timer
            if (run32 && zero32 && amode_r == MODE_ONESHOT)
                ctl_r[CTL_A_EN] <= 1'b0;
            if (run_a && zero_a && amode_r == MODE_ONESHOT)
                ctl_r[CTL_A_EN] <= 1'b0;
            if (run_b && zero_b && bmode_r == MODE_ONESHOT)
                ctl_r[CTL_B_EN] <= 1'b0;
        end
    end

    // clock mode first selection marker
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            clk_seen_r <= 1'b0;
        else if (clk_mode)
            clk_seen_r <= 1'b1;
    end

    // load registers: a 32-bit write fills both halves
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            load_a_r <= RST_LOAD;
            load_b_r <= RST_LOAD;
        end
        else if (wr_go && hit(req.addr, ADDR_AILR))
        begin
            load_a_r <= req.data[15:0];
            if (is32)
                load_b_r <= req.data[31:16];
        end
        else if (wr_go && hit(req.addr, ADDR_BILR))
            load_b_r <= req.data[15:0];
    end

    // counters for all three uses
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            cnt_a_r <= RST_COUNT;
            cnt_b_r <= RST_COUNT;
        end
        else if (clk_mode)
        begin
            if (!clk_seen_r)
                {cnt_b_r, cnt_a_r} <= CLK_FIRST;
            else if (clk_match)
                {cnt_b_r, cnt_a_r} <= CLK_ROLL;
            else if (ctl_r[CTL_A_EN] && tick_1hz)
                {cnt_b_r, cnt_a_r} <= cnt32 + 32'h1;
        end
        else if (cfg_r == CFG_32_TIMER)
        begin
            // a new load is taken at once, even mid-count
            if (wr_go && hit(req.addr, ADDR_AILR))
                {cnt_b_r, cnt_a_r} <= {req.data[31:16],
                                       req.data[15:0]};
            else if (run32 && zero32)
                {cnt_b_r, cnt_a_r} <= load32;
            else if (run32)
                {cnt_b_r, cnt_a_r} <= cnt32 - 32'h1;
        end
        else
        begin
            if (wr_go && hit(req.addr, ADDR_AILR))
                cnt_a_r <= req.data[15:0];
            else if (run_a)
                cnt_a_r <= zero_a ? load_a_r : cnt_a_r - 16'h1;
            if (wr_go && hit(req.addr, ADDR_BILR))
                cnt_b_r <= req.data[15:0];
            else if (run_b)
                cnt_b_r <= zero_b ? load_b_r : cnt_b_r - 16'h1;
        end
    end

    // trigger pulse, one cycle on each zero with trigger enabled
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            trig_r <= 1'b0;
        else
            trig_r <= (run32 && zero32 && ctl_r[CTL_A_OTE])
                      || (run_a && zero_a && ctl_r[CTL_A_OTE])
                      || (run_b && zero_b && ctl_r[CTL_B_OTE]);
    end
    assign ADC_TRIG_O = trig_r;

    // interrupt line, registered from masked flags
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= |(raw_r & imask_r);
    end

    // bus answer: ack one cycle after the request, read data with it
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end
        else
        begin
            ack_r <= bus_go;
            if (bus_go && !req.wr)
            begin
                case (req.addr)
                    ADDR_CFG:    dat_r <= {29'h0, cfg_r};
                    ADDR_AMODE:  dat_r <= {30'h0, amode_r};
                    ADDR_BMODE:  dat_r <= {30'h0, bmode_r};
                    ADDR_CTL:    dat_r <= {16'h0, ctl_r};
                    ADDR_IMASK:  dat_r <= {16'h0, imask_r};
                    ADDR_RAW:    dat_r <= {16'h0, raw_r};
                    ADDR_MSK:    dat_r <= {16'h0, raw_r & imask_r};
                    ADDR_AILR:   dat_r <= is32 ? load32
                                               : {16'h0, ha_r.load};
                    ADDR_BILR:   dat_r <= {16'h0, hb_r.load};
                    ADDR_AMATCH: dat_r <= is32 ? {bmatch_r, amatch_r}
                                               : {16'h0, amatch_r};
                    ADDR_BMATCH: dat_r <= {16'h0, bmatch_r};
                    ADDR_APRE:   dat_r <= {24'h0, apre_r};
                    ADDR_BPRE:   dat_r <= {24'h0, bpre_r};
                    ADDR_ACNT:   dat_r <= is32 ? cnt32
                                               : {16'h0, ha_r.cnt};
                    ADDR_BCNT:   dat_r <= {16'h0, hb_r.cnt};
                    default:     dat_r <= 32'h0;
                endcase
            end
        end
    end
    assign ACK_O = ack_r;
    assign DAT_O = dat_r;

endmodule

/* File: verif/gtu_checker.sv */
// checker: port-level assertions for the general timer unit
`timescale 1ns/1ps
module gtu_checker
    import gtu_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    // wishbone
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic [31:0] DAT_O,
    input  wire logic        ACK_O,
    // pins and outputs
    input  wire logic        CCP_EVEN_I,
    input  wire logic        CCP_ODD_I,
    input  wire logic        ADC_TRIG_O,
    input  wire logic        IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    // a request is taken only while no ack is pending
    wire logic take = CYC_I && STB_I && !ACK_O;

    // bus handshake
    a_ack_follows: assert property (take |=> ACK_O)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_unmapped_zero: assert property
        (take && !WE_I && ADR_I == 8'h40 |=> DAT_O == 32'h0)
        else $error("unmapped read not zero");
    // timer outputs
    a_trig_one_cycle: assert property (ADC_TRIG_O |=> !ADC_TRIG_O)
        else $error("trigger pulse wider than one cycle");
    a_quiet_reset: assert property
        ($rose(ARST_N_I) |-> !(ACK_O || ADC_TRIG_O || IRQ_O))
        else $error("output active after reset");
    a_mask_off_irq: assert property (take && WE_I && SEL_I[0] &&
        ADR_I == ADDR_IMASK && DAT_I == 32'h0 |=> ##1 !IRQ_O)
        else $error("irq stays with mask cleared");
    // raw flags are sticky, so irq only drops after a write
    a_irq_drop_cause: assert property
        ($fell(IRQ_O) |-> $past(CYC_I && STB_I && WE_I, 2))
        else $error("irq dropped without software write");

    c_trig: cover property (ADC_TRIG_O);
    c_irq_drop: cover property ($fell(IRQ_O));
    c_write: cover property (take && WE_I);
endmodule

/* File: verif/gtu_pin_model.sv */
// far side: slow clock on the even capture pin, pattern on the odd one
`timescale 1ns/1ps
module gtu_pin_model (
    // clock and control
    input  wire logic clk_i,
    input  wire logic run_i,
    // capture pins
    output logic      even_o,
    output logic      odd_o
);
    // half period of a 32.768 kHz clock at 100 MHz
    localparam int HALF = 1526;
    int div = 0;
    initial even_o = 1'b0;
    initial odd_o = 1'b0;
    // source stands low outside clock mode, as a gated oscillator would
    always @(posedge clk_i)
    begin
        div <= (div == HALF - 1) ? 0 : div + 1;
        if (!run_i)
            even_o <= 1'b0;
        else if (div == HALF - 1)
            even_o <= ~even_o;
        odd_o <= ~odd_o;
    end
endmodule

/* File: verif/tb_top.sv */
// testbench: bus driver, reference figures and scenarios for the timer unit
`timescale 1ns/1ps
module tb_top;
    import gtu_pkg::*;
    localparam logic [31:0] C_EN  = 32'h1 << CTL_A_EN;
    localparam logic [31:0] C_STL = 32'h1 << CTL_A_STALL;
    localparam logic [31:0] C_OTE = 32'h1 << CTL_A_OTE;
    localparam logic [31:0] C_BEN = 32'h1 << CTL_B_EN;
    localparam logic [31:0] F_A   = 32'h1 << IRQ_A_TIMEOUT;
    localparam logic [31:0] F_B   = 32'h1 << IRQ_B_TIMEOUT;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    gtu_req_s    req;
    logic [31:0] rdat;
    logic        ack;
    logic        pin_even;
    logic        pin_odd;
    logic        pin_run;
    logic        trig;
    logic        irq;
    logic [31:0] q;
    logic [31:0] v;
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          trig_seen = 0;
    int          ld;

    gtu_top gtu_top_i (.CLK_I(clk), .ARST_N_I(rst_n), .CYC_I(cyc),
        .STB_I(stb), .WE_I(req.wr), .ADR_I(req.addr), .SEL_I(req.sel),
        .DAT_I(req.data), .DAT_O(rdat), .ACK_O(ack),
        .CCP_EVEN_I(pin_even), .CCP_ODD_I(pin_odd),
        .ADC_TRIG_O(trig), .IRQ_O(irq));
    gtu_pin_model gtu_pin_model_i (.clk_i(clk), .run_i(pin_run),
        .even_o(pin_even), .odd_o(pin_odd));

    // clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic cycle; the wait is bounded so a dead slave cannot hang
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        req <= '{wr: w, addr: a, data: d, sel: 4'hF};
        @(posedge clk);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
            chk(32'h0, 32'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    // cycle count, trigger pulse count and the hang limit
    always @(posedge clk)
    begin
        cycles++;
        if (trig === 1'b1)
            trig_seen++;
        if (cycles == 12000)
        begin
            err_count++;
            $display("unexpected timeout at %0t: %h %h", $time, cycles, 0);
            conclude();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        req = '0;
        pin_run = 1'b0;
        q = $urandom(75);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // reset state: nothing configured, counts and loads all ones
        rd_chk(ADDR_CFG, 32'h0);
        rd_chk(ADDR_CTL, 32'h0);
        rd_chk(ADDR_ACNT, 32'hFFFFFFFF);
        rd_chk(ADDR_APRE, 32'h0);
        rd_chk(ADDR_BPRE, 32'h0);
        rd_chk(ADDR_RAW, 32'h0);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rd_chk(8'h40, 32'h0);
        // 32-bit load splits into halves and reaches the count at once
        v = $urandom;
        bus(1'b1, ADDR_AILR, v);
        rd_chk(ADDR_BILR, {16'h0, v[31:16]});
        rd_chk(ADDR_ACNT, v);
        bus(1'b1, ADDR_CTL, C_EN | C_STL);
        rd_chk(ADDR_ACNT, v);
        bus(1'b1, ADDR_CTL, C_EN);
        bus(1'b0, ADDR_ACNT, 32'h0);
        chk(32'(q < v), 32'h1);
        // one-shot, second-half mode says periodic and must not matter
        ld = $urandom_range(51, 20);
        bus(1'b1, ADDR_AMODE, {30'h0, MODE_ONESHOT});
        bus(1'b1, ADDR_BMODE, {30'h0, MODE_PERIODIC});
        bus(1'b1, ADDR_IMASK, F_A);
        bus(1'b1, ADDR_AILR, ld);
        trig_seen = 0;
        bus(1'b1, ADDR_CTL, C_EN | C_OTE);
        repeat (ld + 20) @(posedge clk);
        chk(trig_seen, 32'h1);
        rd_chk(ADDR_CTL, C_OTE);
        rd_chk(ADDR_ACNT, ld);
        rd_chk(ADDR_RAW, F_A);
        rd_chk(ADDR_MSK, F_A);
        chk(irq, 32'h1);
        bus(1'b1, ADDR_ICLR, F_A);
        rd_chk(ADDR_RAW, 32'h0);
        chk(irq, 32'h0);
        // periodic: no pulses without trigger enable, then one per period
        bus(1'b1, ADDR_AMODE, {30'h0, MODE_PERIODIC});
        bus(1'b1, ADDR_BMODE, {30'h0, MODE_ONESHOT});
        trig_seen = 0;
        bus(1'b1, ADDR_CTL, C_EN);
        repeat (2 * (ld + 1)) @(posedge clk);
        chk(trig_seen, 32'h0);
        trig_seen = 0;
        bus(1'b1, ADDR_CTL, C_EN | C_OTE);
        repeat (4 * (ld + 1)) @(posedge clk);
        bus(1'b1, ADDR_CTL, 32'h0);
        chk(32'(trig_seen >= 4 && trig_seen <= 6), 32'h1);
        bus(1'b1, ADDR_IMASK, 32'h0);
        rd_chk(ADDR_RAW, F_A);
        rd_chk(ADDR_MSK, 32'h0);
        chk(irq, 32'h0);
        // clock mode starts at one; one second is out of reach here
        bus(1'b1, ADDR_CFG, {29'h0, CFG_32_CLOCK});
        rd_chk(ADDR_CFG, 32'h1);
        rd_chk(ADDR_ACNT, CLK_FIRST);
        pin_run <= 1'b1;
        bus(1'b1, ADDR_CTL, C_EN | C_STL | (32'h1 << CTL_CLK_EN));
        repeat (3200) @(posedge clk);
        rd_chk(ADDR_ACNT, CLK_FIRST);
        bus(1'b1, ADDR_CTL, 32'h0);
        pin_run <= 1'b0;
        // split halves time out on their own flags
        bus(1'b1, ADDR_CFG, {29'h0, CFG_16_SPLIT});
        rd_chk(ADDR_CFG, 32'h4);
        bus(1'b1, ADDR_ICLR, 32'hFFFFFFFF);
        bus(1'b1, ADDR_BMODE, {30'h0, MODE_PERIODIC});
        bus(1'b1, ADDR_CTL, C_EN | C_BEN);
        repeat (200) @(posedge clk);
        rd_chk(ADDR_RAW, F_A | F_B);
        // clock mode chosen again: the start value is loaded only once
        bus(1'b1, ADDR_CTL, 32'h0);
        bus(1'b0, ADDR_ACNT, 32'h0);
        v = q;
        bus(1'b0, ADDR_BCNT, 32'h0);
        v[31:16] = q[15:0];
        bus(1'b1, ADDR_CFG, {29'h0, CFG_32_CLOCK});
        rd_chk(ADDR_ACNT, v);
        // reset in mid-run returns to the idle state
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_CFG, 32'h0);
        rd_chk(ADDR_ACNT, 32'hFFFFFFFF);
        conclude();
    end
endmodule

bind gtu_top gtu_checker gtu_checker_i (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .CCP_EVEN_I(CCP_EVEN_I), .CCP_ODD_I(CCP_ODD_I),
    .ADC_TRIG_O(ADC_TRIG_O), .IRQ_O(IRQ_O));
